/* File: design/background_debug_controller.v */
// Target-side single-wire background debug controller
//
// How it works
// - Commands and data go MSB first.
// - Speed-sync request returns timed response pulse.
// - Pin level at reset selects startup mode.
// - Pull-up on pin selects user mode.
// - Register, step, go only while halted.
// - Memory and status commands work anytime.
// - Halt request wakes from stop or wait.
// - Exactly one hardware address breakpoint comparator.
// - Oscillator kept running while controller enabled.
// - Watchdog held off in background mode.
// - Registers reachable only through serial commands.
// - Link works anytime without device reset.
// - Brief active-high speedup pulses on pin.
// - Debug clock from bus or local clock.
// - Bit nominally sixteen debug clock cycles.
// - 512-cycle gap aborts command harmlessly.
// - Host bits sampled ten cycles after edge.
// - Sending zero: low thirteen cycles, then pulse.
`timescale 1ns/1ps
`default_nettype none
`include "debug_link_map.vh"

module background_debug_controller #(
	parameter [7:0] TICK_DIV = 8'h01
) (
	input  wire        CLK,
	input  wire        SYS_RST,
	input  wire        DEBUG_PIN_I,
	output wire        DEBUG_PIN_O,
	output wire        DEBUG_PIN_OE,
	output wire        PULLUP_EN,
	input  wire        ALT_CLK_TICK,
	output reg         BOOT_BKG,
	input  wire        CPU_HALTED,
	output reg         HALT_REQ,
	output reg         GO_REQ,
	output reg         STEP_REQ,
	output reg  [2:0]  REG_SEL,
	output reg  [15:0] REG_WDATA,
	output reg         REG_WR,
	input  wire [15:0] REG_RDATA,
	output reg  [15:0] MEM_ADDR,
	output reg  [7:0]  MEM_WDATA,
	output reg         MEM_RD,
	output reg         MEM_WR,
	input  wire [7:0]  MEM_RDATA,
	input  wire        MEM_ACK,
	input  wire [15:0] CPU_ADDR,
	input  wire        CPU_FETCH,
	output reg         BKPT_HIT,
	output reg         WDOG_HOLD,
	output reg         OSC_KEEP
);

	localparam ST_CMD = 4'b0001;
	localparam ST_RX  = 4'b0010;
	localparam ST_MEM = 4'b0100;
	localparam ST_TX  = 4'b1000;

	reg  [3:0]  st_q;
	reg  [15:0] sr_q;
	reg  [4:0]  nb_q;
	reg  [7:0]  cmd_q;
	reg         phase_q;
	reg         en_q;
	reg         bkpt_en_q;
	reg         clksw_q;
	reg  [15:0] bkpt_q;
	reg         pin_m_q;
	reg         pin_s_q;
	reg  [1:0]  rst_cnt_q;
	reg  [7:0]  div_q;

	wire        rx_valid;
	wire        rx_bit;
	wire        tx_done;
	wire        sync_done;
	wire        timeout;
	wire        div_tick;
	wire        tick;
	wire [7:0]  rx_byte;
	wire [15:0] rx_word;
	wire [7:0]  status;
	wire        last;

	// The on-chip pull-up stays on so an unconnected pin reads high
	assign PULLUP_EN = 1'b1;

	assign div_tick = (div_q == TICK_DIV - 8'h01);
	assign tick     = clksw_q ? ALT_CLK_TICK : div_tick;
	assign rx_byte  = {sr_q[6:0], rx_bit};
	assign rx_word  = {sr_q[14:0], rx_bit};
	assign last     = (nb_q == 5'h01);
	assign status   = {en_q, CPU_HALTED, bkpt_en_q, clksw_q, 4'h0};

	// The pin arrives from the pod's clock domain
	always @(posedge CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			pin_m_q <= 1'b1;
			pin_s_q <= 1'b1;
		end else begin
			pin_m_q <= DEBUG_PIN_I;
			pin_s_q <= pin_m_q;
		end
	end

	// Debug clock enable; one bit spans sixteen of these ticks
	always @(posedge CLK or posedge SYS_RST) begin
		if (SYS_RST)
			div_q <= 8'h00;
		else if (div_tick)
			div_q <= 8'h00;
		else
			div_q <= div_q + 8'h01;
	end

	// Mode strap: taken once the synchroniser holds post-release levels
	always @(posedge CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			rst_cnt_q <= 2'h0;
			BOOT_BKG  <= 1'b0;
		end else if (rst_cnt_q != 2'h3) begin
			rst_cnt_q <= rst_cnt_q + 2'h1;
			if (rst_cnt_q == 2'h2)
				BOOT_BKG <= ~pin_s_q;
		end
	end

	// Side outputs that follow controller state
	always @(posedge CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			BKPT_HIT  <= 1'b0;
			WDOG_HOLD <= 1'b0;
			OSC_KEEP  <= 1'b0;
		end else begin
			// Single comparator on the fetch address
			BKPT_HIT  <= bkpt_en_q & CPU_FETCH & ~CPU_HALTED &
				(CPU_ADDR == bkpt_q);
			WDOG_HOLD <= CPU_HALTED;
			OSC_KEEP  <= en_q;
		end
	end

	wire_bit_engine engine (
		.clk       (CLK),
		.rst       (SYS_RST),
		.tick      (tick),
		.pin_s     (pin_s_q),
		.tx_en     (st_q == ST_TX),
		.tx_bit    (sr_q[15]),
		.rx_valid  (rx_valid),
		.rx_bit    (rx_bit),
		.tx_done   (tx_done),
		.sync_done (sync_done),
		.timeout   (timeout),
		.pin_o     (DEBUG_PIN_O),
		.pin_oe    (DEBUG_PIN_OE)
	);

	// Command sequencer. Memory is only touched after the last field
	// has arrived, so an abort never leaves a partial write behind.
	always @(posedge CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			st_q      <= ST_CMD;
			sr_q      <= 16'h0000;
			nb_q      <= 5'h08;
			cmd_q     <= 8'h00;
			phase_q   <= 1'b0;
			en_q      <= `CTL_ENABLE_RST;
			bkpt_en_q <= `CTL_BKPT_EN_RST;
			clksw_q   <= `CTL_CLKSW_RST;
			bkpt_q    <= `BKPT_RST;
			HALT_REQ  <= 1'b0;
			GO_REQ    <= 1'b0;
			STEP_REQ  <= 1'b0;
			REG_SEL   <= 3'h0;
			REG_WDATA <= 16'h0000;
			REG_WR    <= 1'b0;
			MEM_ADDR  <= 16'h0000;
			MEM_WDATA <= 8'h00;
			MEM_RD    <= 1'b0;
			MEM_WR    <= 1'b0;
		end else begin
			HALT_REQ <= 1'b0;
			GO_REQ   <= 1'b0;
			STEP_REQ <= 1'b0;
			REG_WR   <= 1'b0;
			if ((timeout || sync_done) && st_q != ST_MEM) begin
				st_q    <= ST_CMD;
				nb_q    <= 5'h08;
				phase_q <= 1'b0;
			end else begin
				case (st_q)
				ST_CMD: begin
					// Listening needs no prior reset of the device
					if (rx_valid) begin
						sr_q <= rx_word;
						nb_q <= nb_q - 5'h01;
						if (last) begin
							cmd_q   <= rx_byte;
							nb_q    <= 5'h08;
							phase_q <= 1'b0;
							if (rx_byte == `CMD_STATUS_RD) begin
								sr_q <= {status, 8'h00};
								st_q <= ST_TX;
							end else if (rx_byte == `CMD_BKPT_RD) begin
								sr_q <= bkpt_q;
								nb_q <= 5'h10;
								st_q <= ST_TX;
							end else if (rx_byte == `CMD_CONTROL_WR) begin
								st_q <= ST_RX;
							end else if (rx_byte == `CMD_BKPT_WR ||
								rx_byte == `CMD_MEM_RD ||
								rx_byte == `CMD_MEM_WR ||
								rx_byte[7:3] == `CMD_REG_WR_HI) begin
								nb_q <= 5'h10;
								st_q <= ST_RX;
							end else if (rx_byte[7:3] == `CMD_REG_RD_HI) begin
								REG_SEL <= rx_byte[2:0];
								st_q    <= ST_MEM;
							end else if (rx_byte == `CMD_BACKGROUND) begin
								// Also the wake-up path out of stop or wait
								HALT_REQ <= en_q;
							end else if (rx_byte == `CMD_GO) begin
								GO_REQ <= CPU_HALTED;
							end else if (rx_byte == `CMD_STEP) begin
								STEP_REQ <= CPU_HALTED;
							end
						end
					end
				end
				ST_RX: begin
					if (rx_valid) begin
						sr_q <= rx_word;
						nb_q <= nb_q - 5'h01;
						if (last) begin
							st_q <= ST_CMD;
							nb_q <= 5'h08;
							if (cmd_q == `CMD_CONTROL_WR) begin
								en_q      <= rx_byte[`CTL_ENABLE_BIT];
								bkpt_en_q <= rx_byte[`CTL_BKPT_EN_BIT];
								clksw_q   <= rx_byte[`CTL_CLKSW_BIT];
							end else if (cmd_q == `CMD_BKPT_WR) begin
								bkpt_q <= rx_word;
							end else if (cmd_q == `CMD_MEM_RD) begin
								MEM_ADDR <= rx_word;
								MEM_RD   <= 1'b1;
								st_q     <= ST_MEM;
							end else if (cmd_q == `CMD_MEM_WR) begin
								if (!phase_q) begin
									MEM_ADDR <= rx_word;
									phase_q  <= 1'b1;
									st_q     <= ST_RX;
								end else begin
									MEM_WDATA <= rx_byte;
									MEM_WR    <= 1'b1;
									st_q      <= ST_MEM;
								end
							end else if (CPU_HALTED) begin
								REG_SEL   <= cmd_q[2:0];
								REG_WDATA <= rx_word;
								REG_WR    <= 1'b1;
							end
						end
					end
				end
				ST_MEM: begin
					if (cmd_q[7:3] == `CMD_REG_RD_HI) begin
						// A running program has no stable registers
						sr_q <= CPU_HALTED ? REG_RDATA : 16'h0000;
						nb_q <= 5'h10;
						st_q <= ST_TX;
					end else if (MEM_ACK) begin
						MEM_RD <= 1'b0;
						MEM_WR <= 1'b0;
						if (MEM_RD) begin
							sr_q <= {MEM_RDATA, 8'h00};
							nb_q <= 5'h08;
							st_q <= ST_TX;
						end else begin
							nb_q <= 5'h08;
							st_q <= ST_CMD;
						end
					end
				end
				ST_TX: begin
					if (tx_done) begin
						sr_q <= {sr_q[14:0], 1'b0};
						nb_q <= nb_q - 5'h01;
						if (last) begin
							nb_q <= 5'h08;
							st_q <= ST_CMD;
						end
					end
				end
				default: begin
					st_q <= ST_CMD;
					nb_q <= 5'h08;
				end
				endcase
			end
		end
	end

endmodule // background_debug_controller
`default_nettype wire

/* File: inc/debug_link_map.vh */
// Command codes, control bit positions and timing counts of the debug link
`ifndef DEBUG_LINK_MAP_VH
`define DEBUG_LINK_MAP_VH

// Command codes, eight bits, sent most significant bit first
`define CMD_BACKGROUND   8'h90
`define CMD_STATUS_RD    8'he4
`define CMD_CONTROL_WR   8'hc4
`define CMD_MEM_RD       8'he0
`define CMD_MEM_WR       8'hc0
`define CMD_BKPT_RD      8'he2
`define CMD_BKPT_WR      8'hc2
`define CMD_GO           8'h08
`define CMD_STEP         8'h10
// Processor register access: upper five bits, low three select the register
`define CMD_REG_WR_HI    5'h08
`define CMD_REG_RD_HI    5'h0c

// Status and control byte layout
`define CTL_ENABLE_BIT   7
`define CTL_HALTED_BIT   6
`define CTL_BKPT_EN_BIT  5
`define CTL_CLKSW_BIT    4
`define CTL_ENABLE_RST   1'h0
`define CTL_BKPT_EN_RST  1'h0
`define CTL_CLKSW_RST    1'h0
`define BKPT_RST         16'h0000

// Timing, in debug clock cycles
`define BIT_TICKS        16
`define SAMPLE_TICK      8'h0a
`define ONE_PULSE_TICK   8'h07
`define ZERO_LOW_TICKS   8'h0d
`define TIMEOUT_TICKS    10'h200
`define SYNC_LOW_TICKS   8'h80
`define SYNC_RESP_TICKS  8'h80

`endif

/* File: design/wire_bit_engine.v */
// Bit-level timing engine of the single-wire debug pin
`timescale 1ns/1ps
`default_nettype none
`include "debug_link_map.vh"

module wire_bit_engine (
	input  wire       clk,
	input  wire       rst,
	input  wire       tick,
	input  wire       pin_s,
	input  wire       tx_en,
	input  wire       tx_bit,
	output reg        rx_valid,
	output reg        rx_bit,
	output reg        tx_done,
	output reg        sync_done,
	output reg        timeout,
	output reg        pin_o,
	output reg        pin_oe
);

	localparam E_IDLE = 3'b001;
	localparam E_BIT  = 3'b010;
	localparam E_SYNC = 3'b100;

	reg [2:0] st_q;
	reg [7:0] cnt_q;
	reg [9:0] gap_q;
	reg       pin_d_q;
	reg       smp_q;
	reg       long_q;
	reg       txing_q;
	reg       txv_q;

	wire fall     = pin_d_q & ~pin_s;
	wire gap_end  = tick & (gap_q == `TIMEOUT_TICKS - 10'h001);

	always @(posedge clk or posedge rst) begin
		if (rst) begin
			st_q      <= E_IDLE;
			cnt_q     <= 8'h00;
			gap_q     <= 10'h000;
			pin_d_q   <= 1'b1;
			smp_q     <= 1'b1;
			long_q    <= 1'b0;
			txing_q   <= 1'b0;
			txv_q     <= 1'b0;
			rx_valid  <= 1'b0;
			rx_bit    <= 1'b0;
			tx_done   <= 1'b0;
			sync_done <= 1'b0;
			timeout   <= 1'b0;
			pin_o     <= 1'b0;
			pin_oe    <= 1'b0;
		end else begin
			rx_valid  <= 1'b0;
			tx_done   <= 1'b0;
			sync_done <= 1'b0;
			timeout   <= 1'b0;
			pin_d_q   <= pin_s;
			if (fall)
				gap_q <= 10'h000;
			else if (tick && gap_q != `TIMEOUT_TICKS)
				gap_q <= gap_q + 10'h001;
			if (gap_end)
				timeout <= 1'b1;
			case (st_q)
			E_IDLE: begin
				// Every bit starts at the host's falling edge only
				if (fall) begin
					st_q    <= E_BIT;
					cnt_q   <= 8'h00;
					long_q  <= 1'b0;
					txing_q <= tx_en;
					txv_q   <= tx_bit;
					if (tx_en && !tx_bit) begin
						pin_oe <= 1'b1;
						pin_o  <= 1'b0;
					end
				end
			end
			E_BIT: begin
				if (gap_end) begin
					st_q   <= E_IDLE;
					pin_oe <= 1'b0;
					pin_o  <= 1'b0;
				end else if (tick) begin
					if (cnt_q != 8'hff)
						cnt_q <= cnt_q + 8'h01;
					if (txing_q && txv_q) begin
						// Speedup high pulse after the host has let go
						if (cnt_q == `ONE_PULSE_TICK - 8'h01) begin
							pin_oe <= 1'b1;
							pin_o  <= 1'b1;
						end else if (cnt_q == `ONE_PULSE_TICK) begin
							pin_oe  <= 1'b0;
							pin_o   <= 1'b0;
							tx_done <= 1'b1;
							st_q    <= E_IDLE;
						end
					end else if (txing_q) begin
						if (cnt_q == `ZERO_LOW_TICKS - 8'h01)
							pin_o <= 1'b1;
						else if (cnt_q == `ZERO_LOW_TICKS) begin
							pin_oe  <= 1'b0;
							pin_o   <= 1'b0;
							tx_done <= 1'b1;
							st_q    <= E_IDLE;
						end
					end else begin
						if (cnt_q == `SAMPLE_TICK - 8'h01)
							smp_q <= pin_s;
						if (cnt_q == `SYNC_LOW_TICKS - 8'h01 && !pin_s)
							long_q <= 1'b1;
					end
				end
				// A received bit ends once sampled and the line is high
				if (!txing_q && !gap_end && pin_s && cnt_q > `SAMPLE_TICK - 8'h01) begin
					if (long_q) begin
						st_q   <= E_SYNC;
						cnt_q  <= 8'h00;
						pin_oe <= 1'b1;
						pin_o  <= 1'b0;
					end else begin
						st_q     <= E_IDLE;
						rx_valid <= 1'b1;
						rx_bit   <= smp_q;
					end
				end
			end
			E_SYNC: begin
				if (tick) begin
					cnt_q <= cnt_q + 8'h01;
					if (cnt_q == `SYNC_RESP_TICKS - 8'h01)
						pin_o <= 1'b1;
					else if (cnt_q == `SYNC_RESP_TICKS) begin
						pin_oe    <= 1'b0;
						pin_o     <= 1'b0;
						sync_done <= 1'b1;
						st_q      <= E_IDLE;
					end
				end
			end
			default: begin
				st_q   <= E_IDLE;
				pin_oe <= 1'b0;
				pin_o  <= 1'b0;
			end
			endcase
		end
	end

endmodule // wire_bit_engine
`default_nettype wire

/* File: dv/background_debug_controller_assertions.sv */
// Port checks of the background debug controller
`timescale 1ns/1ps
`default_nettype none
module debug_port_checker #(
	parameter [7:0] TICK_DIV = 8'h01
) (
	input wire logic        CLK,
	input wire logic        SYS_RST,
	input wire logic        DEBUG_PIN_O,
	input wire logic        DEBUG_PIN_OE,
	input wire logic        PULLUP_EN,
	input wire logic        CPU_HALTED,
	input wire logic        HALT_REQ,
	input wire logic        GO_REQ,
	input wire logic        STEP_REQ,
	input wire logic        REG_WR,
	input wire logic [15:0] MEM_ADDR,
	input wire logic [7:0]  MEM_WDATA,
	input wire logic        MEM_RD,
	input wire logic        MEM_WR,
	input wire logic        MEM_ACK,
	input wire logic        CPU_FETCH,
	input wire logic        BKPT_HIT,
	input wire logic        WDOG_HOLD
);
	logic [15:0] low_n_q;
	wire logic   low_drv = DEBUG_PIN_OE && !DEBUG_PIN_O;
	wire logic   hi_drv = DEBUG_PIN_OE && DEBUG_PIN_O;
	wire logic   mem_req = MEM_RD || MEM_WR;
	// Run length of a low drive tells a zero bit from a sync answer
	always @(posedge CLK or posedge SYS_RST)
		if (SYS_RST)
			low_n_q <= 16'h0000;
		else
			low_n_q <= low_drv ? low_n_q + 16'h0001 : 16'h0000;
	default clocking @(posedge CLK); endclocking
	default disable iff (SYS_RST);
	a_pullup_on: assert property (PULLUP_EN)
		else $error("pull-up not enabled");
	// Drive starts between ticks, so the first tick may come early
	a_low_length: assert property ($fell(low_drv) |-> hi_drv &&
		((low_n_q > 12 * TICK_DIV && low_n_q <= 13 * TICK_DIV) ||
		(low_n_q > 127 * TICK_DIV && low_n_q <= 128 * TICK_DIV)))
		else $error("low drive of wrong length");
	// Holds for a one-tick pulse only while a tick spans at most two clocks
	a_speedup_brief: assert property (hi_drv [*2] |=> !hi_drv)
		else $error("speedup pulse too long");
	a_bkpt_cause: assert property (BKPT_HIT |->
		$past(CPU_FETCH) && !$past(CPU_HALTED))
		else $error("breakpoint hit without halted-free fetch");
	a_wdog_follow: assert property (!$past(SYS_RST) |->
		WDOG_HOLD == $past(CPU_HALTED))
		else $error("watchdog hold not following halt");
	a_go_halted: assert property (GO_REQ |-> CPU_HALTED)
		else $error("go while running");
	a_step_halted: assert property (STEP_REQ |-> CPU_HALTED)
		else $error("step while running");
	a_regwr_halted: assert property (REG_WR |-> CPU_HALTED)
		else $error("register write while running");
	a_halt_pulse: assert property (HALT_REQ |=> !HALT_REQ)
		else $error("halt request longer than one cycle");
	a_mem_held: assert property (mem_req && !MEM_ACK |=>
		mem_req && $stable(MEM_ADDR) && $stable(MEM_WDATA))
		else $error("memory request dropped before ack");
	c_sync_answer: cover property ($fell(low_drv) && low_n_q > 127 * TICK_DIV);
	c_bkpt_hit: cover property (BKPT_HIT);
	c_mem_write: cover property (MEM_WR && MEM_ACK);
	c_go: cover property (GO_REQ);
endmodule // debug_port_checker
bind background_debug_controller debug_port_checker #(
	.TICK_DIV(TICK_DIV)
) port_chk (.CLK, .SYS_RST, .DEBUG_PIN_O, .DEBUG_PIN_OE, .PULLUP_EN,
	.CPU_HALTED, .HALT_REQ, .GO_REQ, .STEP_REQ, .REG_WR, .MEM_ADDR,
	.MEM_WDATA, .MEM_RD, .MEM_WR, .MEM_ACK, .CPU_FETCH, .BKPT_HIT,
	.WDOG_HOLD);
`default_nettype wire

/* File: dv/debug_pod_model.sv */
// Debug pod model that pulls the debug pin low
`timescale 1ns/1ps
`default_nettype none
module debug_pod_model (
	input  wire logic clk,
	input  wire logic pin,
	input  wire logic tgt_oe,
	input  wire logic tgt_o,
	output var logic  low_q,
	output var logic  clash_q
);
	initial begin
		low_q = 1'b0;
		clash_q = 1'b0;
	end
	// Pod never drives high, so target high drive over a pod low is a clash
	always @(posedge clk)
		if (low_q && tgt_oe && tgt_o)
			clash_q <= 1'b1;
	task automatic hold_low(input int n);
		@(posedge clk) low_q <= 1'b1;
		repeat (n) @(posedge clk);
		low_q <= 1'b0;
	endtask
	// A zero is held past the target sample point, a one released early
	task automatic bit_io(input logic b, output logic r);
		hold_low(b ? 3 : 28);
		repeat (18) @(posedge clk);
		r = pin;
		repeat (20) @(posedge clk);
	endtask
	task automatic byte_io(input logic [7:0] tx, output logic [7:0] rx);
		for (int i = 7; i >= 0; i--)
			bit_io(tx[i], rx[i]);
	endtask
endmodule // debug_pod_model
`default_nettype wire

/* File: dv/background_debug_controller_bench.sv */
// Self-checking bench of the background debug controller
`timescale 1ns/1ps
`default_nettype none
module background_debug_controller_bench;
	logic        CLK = 1'b0, SYS_RST = 1'b1, ALT_CLK_TICK = 1'b0;
	logic        CPU_HALTED = 1'b0, MEM_ACK = 1'b0, CPU_FETCH = 1'b0;
	logic [7:0]  MEM_RDATA = 8'h00;
	logic [15:0] CPU_ADDR = 16'h0000;
	logic        DEBUG_PIN_O, DEBUG_PIN_OE, PULLUP_EN, BOOT_BKG, HALT_REQ;
	logic        GO_REQ, STEP_REQ, REG_WR, MEM_RD, MEM_WR, BKPT_HIT;
	logic        WDOG_HOLD, OSC_KEEP, low_q, clash_q;
	logic [2:0]  REG_SEL, rs_q;
	logic [15:0] REG_WDATA, MEM_ADDR, REG_RDATA, aw_q, rw_q;
	logic [7:0]  MEM_WDATA, mem_q [16];
	logic [1:0]  d_q = 2'h0;
	wire logic   DEBUG_PIN_I = DEBUG_PIN_OE ? DEBUG_PIN_O : !low_q;
	int          err_count = 0, total_checks = 0, n_halt = 0, n_go = 0;
	int          n_step = 0, n_regwr = 0, n_memwr = 0;
	assign REG_RDATA = {8'ha5, 5'h00, REG_SEL};
	background_debug_controller #(.TICK_DIV(8'h02)) dut (.CLK, .SYS_RST,
		.DEBUG_PIN_I, .DEBUG_PIN_O, .DEBUG_PIN_OE, .PULLUP_EN, .ALT_CLK_TICK,
		.BOOT_BKG, .CPU_HALTED, .HALT_REQ, .GO_REQ, .STEP_REQ, .REG_SEL,
		.REG_WDATA, .REG_WR, .REG_RDATA, .MEM_ADDR, .MEM_WDATA, .MEM_RD,
		.MEM_WR, .MEM_RDATA, .MEM_ACK, .CPU_ADDR, .CPU_FETCH, .BKPT_HIT,
		.WDOG_HOLD, .OSC_KEEP);
	debug_pod_model pod (.clk(CLK), .pin(DEBUG_PIN_I), .tgt_oe(DEBUG_PIN_OE),
		.tgt_o(DEBUG_PIN_O), .low_q, .clash_q);
	initial forever #5 CLK = !CLK;
	// Alternate tick matches the divided bus tick so bit timing is unchanged
	always @(posedge CLK) begin
		ALT_CLK_TICK <= !ALT_CLK_TICK;
		MEM_ACK <= (MEM_RD | MEM_WR) && !MEM_ACK && d_q == 2'h3;
		d_q <= ((MEM_RD | MEM_WR) && !MEM_ACK) ? d_q + 2'h1 : 2'h0;
		MEM_RDATA <= mem_q[MEM_ADDR[3:0]];
		if (MEM_WR && d_q == 2'h3) begin
			mem_q[MEM_ADDR[3:0]] <= MEM_WDATA;
			aw_q <= MEM_ADDR;
			n_memwr++;
		end
		if (REG_WR) begin
			rw_q <= REG_WDATA;
			rs_q <= REG_SEL;
		end
		if (HALT_REQ)
			CPU_HALTED <= 1'b1;
		if (GO_REQ)
			CPU_HALTED <= 1'b0;
		n_halt += HALT_REQ;
		n_go += GO_REQ;
		n_step += STEP_REQ;
		n_regwr += REG_WR;
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			err_count++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic print_verdict();
		$display("checks %0d errors %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic send(input logic [7:0] c);
		logic [7:0] r;
		pod.byte_io(c, r);
	endtask
	task automatic rd16(output logic [15:0] v);
		pod.byte_io(8'hff, v[15:8]);
		pod.byte_io(8'hff, v[7:0]);
	endtask
	task automatic status(input logic [7:0] exp);
		logic [7:0] r;
		send(8'he4);
		pod.byte_io(8'hff, r);
		chk(r, exp);
	endtask
	task automatic t_sync();
		int n;
		n = 0;
		pod.hold_low(300);
		for (int i = 0; i < 40 && !DEBUG_PIN_OE; i++)
			@(posedge CLK);
		while (DEBUG_PIN_OE && !DEBUG_PIN_O && n < 400) begin
			@(posedge CLK);
			n++;
		end
		// One tick per two clocks: 128 ticks span 255 or 256 clocks by phase
		chk((n + 1) / 2, 128);
		repeat (20) @(posedge CLK);
	endtask
	task automatic t_control();
		status(8'h00);
		send(8'hc4);
		send(8'hb0);
		chk(OSC_KEEP, 1'b1);
		status(8'hb0);
	endtask
	task automatic t_mem();
		logic [7:0] r;
		send(8'hc0);
		send(8'h12);
		send(8'h34);
		send(8'h5a);
		for (int i = 0; i < 60 && aw_q !== 16'h1234; i++)
			@(posedge CLK);
		chk(aw_q, 16'h1234);
		chk(mem_q[4], 8'h5a);
		send(8'he0);
		send(8'h12);
		send(8'h34);
		repeat (40) @(posedge CLK);
		pod.byte_io(8'hff, r);
		chk(r, 8'h5a);
	endtask
	task automatic t_bkpt();
		logic [15:0] v;
		send(8'hc2);
		send(8'h12);
		send(8'h34);
		send(8'he2);
		rd16(v);
		chk(v, 16'h1234);
		CPU_ADDR <= 16'h1234;
		CPU_FETCH <= 1'b1;
		repeat (3) @(posedge CLK);
		chk(BKPT_HIT, 1'b1);
		CPU_ADDR <= 16'h1235;
		repeat (3) @(posedge CLK);
		chk(BKPT_HIT, 1'b0);
		CPU_FETCH <= 1'b0;
	endtask
	task automatic t_active();
		logic [15:0] v;
		send(8'h08);
		send(8'h10);
		send(8'h42);
		send(8'hab);
		send(8'hcd);
		send(8'h63);
		rd16(v);
		chk(v, 16'h0000);
		chk(n_go + n_step + n_regwr, 0);
		send(8'h90);
		repeat (3) @(posedge CLK);
		chk({n_halt[30:0], WDOG_HOLD}, {31'd1, 1'b1});
		send(8'h42);
		send(8'hab);
		send(8'hcd);
		chk({rs_q, rw_q, n_regwr[3:0]}, {3'h2, 16'habcd, 4'h1});
		send(8'h63);
		rd16(v);
		chk(v, 16'ha503);
		send(8'h10);
		send(8'h08);
		repeat (3) @(posedge CLK);
		chk({n_step[15:0], n_go[14:0], WDOG_HOLD}, {16'd1, 15'd1, 1'b0});
	endtask
	task automatic t_timeout();
		int w;
		w = n_memwr;
		send(8'hc0);
		send(8'h12);
		repeat (1100) @(posedge CLK);
		status(8'hb0);
		chk(n_memwr, w);
	endtask
	task automatic t_boot();
		fork
			pod.hold_low(16);
		join_none
		SYS_RST <= 1'b1;
		repeat (4) @(posedge CLK);
		SYS_RST <= 1'b0;
		// The strap's low run is also taken as a bit; let it finish first
		repeat (40) @(posedge CLK);
		chk(BOOT_BKG, 1'b1);
		t_sync();
		status(8'h00);
		chk(OSC_KEEP, 1'b0);
	endtask
	initial begin
		repeat (8) @(posedge CLK);
		chk({DEBUG_PIN_OE, PULLUP_EN, BOOT_BKG, MEM_WR}, 4'h4);
		SYS_RST <= 1'b0;
		repeat (6) @(posedge CLK);
		chk(BOOT_BKG, 1'b0);
		t_sync();
		t_control();
		t_mem();
		t_bkpt();
		t_active();
		t_timeout();
		t_boot();
		chk(clash_q, 1'b0);
		print_verdict();
	end
endmodule // background_debug_controller_bench
`default_nettype wire
